// [src/amp_clock_regs.svh]
// register offsets, field positions, reset values and timing counts of the amplifier control block
// assumes it is included by bare name from a file that uses the macros
`ifndef AMP_CLOCK_REGS_SVH
`define AMP_CLOCK_REGS_SVH

// register offsets on the 3-bit register port
`define OFF_CONTROL_REG_ZERO 3'h0
`define OFF_CONTROL_REG_ONE 3'h1
`define OFF_CONTROL_REG_TWO 3'h2
`define OFF_CONTROL_REG_FIVE 3'h5
`define OFF_COMP_CAP_REG 3'h6
`define OFF_STATUS_REG 3'h7

// field positions
`define POS_DIVIDE_RATIO 0
`define POS_CLOCK_MODE 0
`define POS_CURRENT_LIMIT_THRESHOLD_BIT 2
`define POS_STANDBY 0
`define POS_SOFT_RESET 0
`define POS_SPREAD_EN 1
`define POS_SPREAD_DEPTH 2
`define POS_COMP_CAP 0

// reset values
`define RST_DIVIDE_RATIO 4'h0
`define RST_CLOCK_MODE 2'h0
`define RST_CURRENT_LIMIT_THRESHOLD_BIT 1'h0
`define RST_STANDBY 1'h0
`define RST_SPREAD_EN 1'h0
`define RST_SPREAD_DEPTH 3'h0
`define RST_COMP_CAP 3'h4

// clock mode code that selects the external sync source
`define CLOCK_MODE_SLAVE 2'h1

// oscillator and core rates in kHz; the oscillator tick is a fractional enable
`define OSC_RATE_KHZ 15'h4650
`define CORE_RATE_KHZ 15'h4E20

// oscillator ticks per switching period for the ten master frequencies (750 kHz down to 300 kHz)
`define DIV_COUNT_0 8'h18
`define DIV_COUNT_1 8'h1A
`define DIV_COUNT_2 8'h1C
`define DIV_COUNT_3 8'h1E
`define DIV_COUNT_4 8'h22
`define DIV_COUNT_5 8'h26
`define DIV_COUNT_6 8'h2A
`define DIV_COUNT_7 8'h2E
`define DIV_COUNT_8 8'h34
`define DIV_COUNT_9 8'h3C
`define DIV_CODE_LAST 4'h9

`endif

// [src/amp_clock_pkg.sv]
// types shared by the amplifier mode and switching clock block
// assumes nothing beyond a SystemVerilog compiler
package amp_clock_pkg;

	// operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_STANDBY = 3'b010,
		MODE_NORMAL = 3'b100
	} op_mode_e;

	// host configuration held in the register file
	typedef struct packed {
		logic [3:0] divide_ratio_field;
		logic [1:0] clock_mode_field;
		logic current_limit_threshold_bit;
		logic standby_bit;
		logic spread_enable_bit;
		logic [2:0] spread_depth;
		logic [2:0] comp_cap;
	} cfg_s;

	// diagonal pair drive of one full bridge
	typedef struct packed {
		logic pair_a_on;
		logic pair_b_on;
	} bridge_s;

endpackage

// [src/amp_clock_ctrl.sv]
// amplifier mode control, soft reset and switching clock generation
// assumes a 20 MHz core clock, a plain register port from the serial bus slave and asynchronous pins
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "amp_clock_regs.svh"

module amp_clock_ctrl (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic enable_pin,
	input wire logic mute_or_clip_pin,
	input wire logic sync_pin,
	input wire logic mod_comparator,
	input wire logic [2:0] power_stage_supply_code,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rd_data,
	output logic switch_clk,
	output logic [7:0] ramp_value,
	output amp_clock_pkg::bridge_s bridge_drive,
	output logic [2:0] integ_res_sel,
	output logic [2:0] comp_cap_sel,
	output logic current_limit_threshold_bit,
	output logic fault_mon_en,
	output logic serial_if_en,
	output logic addr_lsb
);

	// reset release and pin synchronisers
	logic [1:0] rst_sync;
	logic rst_n;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= {power_stage_supply_code, mod_comparator, sync_pin, mute_or_clip_pin, enable_pin};
			pin_sync <= pin_meta;
		end
	end

	wire en_s = pin_sync[0];
	wire mute_s = pin_sync[1];
	wire sync_s = pin_sync[2];
	wire comp_s = pin_sync[3];
	wire [2:0] supply_s = pin_sync[6:4];

	// previous samples for edge detection
	logic en_d;
	logic sync_d;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_d <= 1'b0;
			sync_d <= 1'b0;
		end else begin
			en_d <= en_s;
			sync_d <= sync_s;
		end
	end
	wire en_rise = en_s & ~en_d;
	wire sync_rise = sync_s & ~sync_d;

	// register file
	amp_clock_pkg::cfg_s cfg;
	logic soft_rst;
	wire bus_wr = reg_wr & en_s & ~soft_rst;
	wire wr_zero = bus_wr & (reg_addr == `OFF_CONTROL_REG_ZERO);
	wire wr_one = bus_wr & (reg_addr == `OFF_CONTROL_REG_ONE);
	wire wr_two = bus_wr & (reg_addr == `OFF_CONTROL_REG_TWO);
	wire wr_five = bus_wr & (reg_addr == `OFF_CONTROL_REG_FIVE);
	wire wr_comp = bus_wr & (reg_addr == `OFF_COMP_CAP_REG);
	wire clear_regs = soft_rst | ~en_s;

	// soft reset request: set by a write of one, cleared the cycle after
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= wr_five & reg_wr_data[`POS_SOFT_RESET];
		end
	end

	// configuration storage; enable low or soft reset returns reset values
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '{`RST_DIVIDE_RATIO, `RST_CLOCK_MODE, `RST_CURRENT_LIMIT_THRESHOLD_BIT, `RST_STANDBY,
				`RST_SPREAD_EN, `RST_SPREAD_DEPTH, `RST_COMP_CAP};
		end else if (clear_regs) begin
			cfg <= '{`RST_DIVIDE_RATIO, `RST_CLOCK_MODE, `RST_CURRENT_LIMIT_THRESHOLD_BIT, `RST_STANDBY,
				`RST_SPREAD_EN, `RST_SPREAD_DEPTH, `RST_COMP_CAP};
		end else begin
			// writes stay live in standby
			if (wr_zero) cfg.divide_ratio_field <= reg_wr_data[`POS_DIVIDE_RATIO +: 4];
			if (wr_one) cfg.clock_mode_field <= reg_wr_data[`POS_CLOCK_MODE +: 2];
			if (wr_one) cfg.current_limit_threshold_bit <= reg_wr_data[`POS_CURRENT_LIMIT_THRESHOLD_BIT];
			if (wr_two) cfg.standby_bit <= reg_wr_data[`POS_STANDBY];
			if (wr_five) cfg.spread_enable_bit <= reg_wr_data[`POS_SPREAD_EN];
			if (wr_five) cfg.spread_depth <= reg_wr_data[`POS_SPREAD_DEPTH +: 3];
			if (wr_comp) cfg.comp_cap <= reg_wr_data[`POS_COMP_CAP +: 3];
		end
	end

	// operating mode
	amp_clock_pkg::op_mode_e mode;
	amp_clock_pkg::op_mode_e next_mode;
	always_comb begin
		case (mode)
			amp_clock_pkg::MODE_OFF: next_mode = en_s ? amp_clock_pkg::MODE_STANDBY : amp_clock_pkg::MODE_OFF;
			amp_clock_pkg::MODE_STANDBY, amp_clock_pkg::MODE_NORMAL: begin
				if (!en_s) begin
					next_mode = amp_clock_pkg::MODE_OFF;
				end else if (cfg.standby_bit) begin
					next_mode = amp_clock_pkg::MODE_STANDBY;
				end else begin
					next_mode = amp_clock_pkg::MODE_NORMAL;
				end
			end
			default: next_mode = amp_clock_pkg::MODE_OFF;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= amp_clock_pkg::MODE_OFF;
		end else begin
			mode <= next_mode;
		end
	end
	wire active = (mode == amp_clock_pkg::MODE_NORMAL) & en_s & ~cfg.standby_bit;
	wire slave_mode = (cfg.clock_mode_field == `CLOCK_MODE_SLAVE);

	// fractional 18 MHz oscillator tick from the 20 MHz core clock
	// one spare bit: the sum reaches almost twice the core rate and must not wrap
	logic [15:0] osc_acc;
	wire [15:0] osc_sum = osc_acc + {1'b0, `OSC_RATE_KHZ};
	wire osc_tick = (osc_sum >= {1'b0, `CORE_RATE_KHZ});
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_acc <= 16'h0000;
		end else begin
			osc_acc <= osc_tick ? osc_sum - {1'b0, `CORE_RATE_KHZ} : osc_sum;
		end
	end

	// divide ratio lookup; codes past the tenth take the slowest rate
	logic [7:0] base_period;
	always_comb begin
		case ((cfg.divide_ratio_field > `DIV_CODE_LAST) ? `DIV_CODE_LAST : cfg.divide_ratio_field)
			4'h0: base_period = `DIV_COUNT_0;
			4'h1: base_period = `DIV_COUNT_1;
			4'h2: base_period = `DIV_COUNT_2;
			4'h3: base_period = `DIV_COUNT_3;
			4'h4: base_period = `DIV_COUNT_4;
			4'h5: base_period = `DIV_COUNT_5;
			4'h6: base_period = `DIV_COUNT_6;
			4'h7: base_period = `DIV_COUNT_7;
			4'h8: base_period = `DIV_COUNT_8;
			default: base_period = `DIV_COUNT_9;
		endcase
	end

	// spread depth: at most about 7 percent of the period at depth seven
	wire spread_on = cfg.spread_enable_bit & ~slave_mode;
	wire [15:0] spread_prod = base_period * cfg.spread_depth * 8'h05;
	wire [7:0] spread_max = spread_on ? spread_prod[15:8] >> 1 : 8'h00;
	logic [7:0] dither;
	logic dither_down;
	wire [7:0] period = base_period + dither; // dither adds whole ticks, keeping the sweep within 7 percent
	wire [7:0] half = {1'b0, period[7:1]};

	// master divider counter with the linear dither sweep
	// a new divide ratio restarts the count so it never sits past a shorter period
	logic [7:0] div_cnt;
	wire period_end = (div_cnt >= period - 8'h01);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			dither <= 8'h00;
			dither_down <= 1'b0;
		end else if (!active || slave_mode || wr_zero || !spread_on && dither != 8'h00) begin
			div_cnt <= 8'h00;
			dither <= 8'h00;
			dither_down <= 1'b0;
		end else if (osc_tick) begin
			div_cnt <= period_end ? 8'h00 : div_cnt + 8'h01;
			if (period_end) begin
				// one step of the sweep per switching cycle
				if (dither_down) begin
					dither <= (dither == 8'h00) ? dither : dither - 8'h01;
					dither_down <= (dither > 8'h01);
				end else begin
					dither <= (dither >= spread_max) ? spread_max : dither + 8'h01;
					dither_down <= (dither + 8'h01 >= spread_max);
				end
			end
		end
	end

	// slave counter: measures the ramp between sync-derived toggles
	logic [7:0] slave_cnt;
	logic slave_phase;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slave_cnt <= 8'h00;
			slave_phase <= 1'b0;
		end else if (!active || !slave_mode) begin
			slave_cnt <= 8'h00;
			slave_phase <= 1'b0;
		end else if (sync_rise) begin
			slave_cnt <= 8'h00;
			slave_phase <= ~slave_phase;
		end else if (slave_cnt != 8'hFF) begin
			slave_cnt <= slave_cnt + 8'h01;
		end
	end

	// switching clock, triangle ramp and double-edge bridge drive
	wire master_phase = (div_cnt >= half);
	wire next_sw = active & (slave_mode ? slave_phase : master_phase);
	wire [7:0] master_ramp = master_phase ? period - div_cnt : div_cnt;
	wire [7:0] slave_ramp = slave_phase ? ~slave_cnt : slave_cnt;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			switch_clk <= 1'b0;
			ramp_value <= 8'h00;
			bridge_drive <= 2'b00;
		end else begin
			switch_clk <= next_sw;
			ramp_value <= !active ? 8'h00 : slave_mode ? slave_ramp : master_ramp;
			bridge_drive.pair_a_on <= active & comp_s;
			bridge_drive.pair_b_on <= active & ~comp_s;
		end
	end

	// analog settings, enables and the latched address bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			integ_res_sel <= 3'h0;
			comp_cap_sel <= `RST_COMP_CAP;
			current_limit_threshold_bit <= `RST_CURRENT_LIMIT_THRESHOLD_BIT;
			fault_mon_en <= 1'b0;
			serial_if_en <= 1'b0;
			addr_lsb <= 1'b0;
		end else begin
			integ_res_sel <= en_s ? supply_s : 3'h0;
			comp_cap_sel <= cfg.comp_cap;
			current_limit_threshold_bit <= cfg.current_limit_threshold_bit;
			fault_mon_en <= en_s;
			serial_if_en <= en_s;
			if (en_rise) addr_lsb <= mute_s;
		end
	end

	// register read port, data one cycle after the strobe
	wire [7:0] status_word = {addr_lsb, supply_s, switch_clk, mode};
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			`OFF_CONTROL_REG_ZERO: rd_mux = {4'h0, cfg.divide_ratio_field};
			`OFF_CONTROL_REG_ONE: rd_mux = {5'h00, cfg.current_limit_threshold_bit, cfg.clock_mode_field};
			`OFF_CONTROL_REG_TWO: rd_mux = {7'h00, cfg.standby_bit};
			`OFF_CONTROL_REG_FIVE: rd_mux = {3'h0, cfg.spread_depth, cfg.spread_enable_bit, soft_rst};
			`OFF_COMP_CAP_REG: rd_mux = {5'h00, cfg.comp_cap};
			`OFF_STATUS_REG: rd_mux = status_word;
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rd_data <= 8'h00;
		end else begin
			reg_rd_data <= (reg_rd & en_s) ? rd_mux : 8'h00;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence enable_rise_s;
		!en_s ##1 en_s;
	endsequence
	sequence comp_write_s;
		wr_comp ##1 1'b1;
	endsequence

	AST_SOFT_RST_CLEARS: assert property (soft_rst |=> !soft_rst && cfg.comp_cap == `RST_COMP_CAP
		&& !cfg.standby_bit) else $error("soft reset did not clear");
	AST_EN_LOW_OFF: assert property (!en_s |=> !fault_mon_en && !serial_if_en && !switch_clk)
		else $error("enable low left logic on");
	AST_STANDBY_QUIET: assert property (en_s && cfg.standby_bit |=> fault_mon_en && !bridge_drive.pair_a_on
		&& !bridge_drive.pair_b_on) else $error("standby left bridge on");
	AST_STANDBY_KEEPS: assert property (en_s && cfg.standby_bit && !bus_wr && !soft_rst |=> $stable(cfg))
		else $error("standby changed registers");
	AST_COMP_IMMEDIATE: assert property (comp_write_s |=> comp_cap_sel == $past(reg_wr_data[2:0], 2))
		else $error("compensation select late");
	AST_ADDR_LATCH: assert property (enable_rise_s |=> addr_lsb == $past(mute_s))
		else $error("address bit not latched");
	AST_BRIDGE_DIAG: assert property (active && $stable(active) |=> bridge_drive.pair_a_on == $past(comp_s)
		&& bridge_drive.pair_b_on != bridge_drive.pair_a_on) else $error("bridge pairs wrong");
	AST_SLAVE_HALF: assert property (active && slave_mode && sync_rise ##1 active && slave_mode
		|=> switch_clk != $past(switch_clk)) else $error("slave clock missed toggle");
	AST_PERIOD_RANGE: assert property (active && !slave_mode |-> period >= `DIV_COUNT_0
		&& period <= `DIV_COUNT_9 + 8'h04 && div_cnt < period) else $error("period out of range");
	AST_SPREAD_MASTER: assert property (slave_mode || !cfg.spread_enable_bit |=> dither == 8'h00)
		else $error("spread outside master");
	AST_SUPPLY_CODE: assert property (en_s ##1 en_s |-> integ_res_sel == $past(supply_s))
		else $error("resistor code stale");

endmodule

`default_nettype wire

// [tb/host_model.sv]
// host side model: drives the register port of the amplifier control block
// assumes a free-running core clock and one task call at a time from the bench
`timescale 1ns/100ps
`default_nettype none
`include "amp_clock_regs.svh"
module host_model (
	input wire logic core_clk,
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wr_data,
	output logic reg_wr,
	output logic reg_rd
);
	// lowest compensation code this host ever programs
	parameter logic [2:0] comp_min = 3'h2;

	// idle bus at time zero
	initial begin
		reg_addr = 3'h0;
		reg_wr_data = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one strobe cycle; released data shows the inverse so stale values never match
	task automatic cyc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= ~w;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wr_data <= ~d;
	endtask

	// compensation writes are clamped to the floor
	task automatic set_comp(input logic [2:0] c);
		cyc(1'b1, `OFF_COMP_CAP_REG, {5'h00, (c < comp_min) ? comp_min : c});
	endtask

	// standby exit with the threshold bit raised around it
	task automatic leave_standby(input logic [7:0] control_reg_one);
		cyc(1'b1, `OFF_CONTROL_REG_ONE, control_reg_one | 8'h04);
		cyc(1'b1, `OFF_CONTROL_REG_TWO, 8'h00);
		cyc(1'b1, `OFF_CONTROL_REG_ONE, control_reg_one & 8'hFB);
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the amplifier mode and switching clock block
// assumes the host model drives the register port; reads are checked from a queue
`timescale 1ns/100ps
`default_nettype none
`include "amp_clock_regs.svh"
module tb_top;
	logic core_clk = 1'b0, arst_n = 1'b0, enable_pin = 1'b0, mute_or_clip_pin = 1'b0;
	logic sync_pin = 1'b0, mod_comparator = 1'b0, rd_d = 1'b0;
	logic [2:0] power_stage_supply_code = 3'h0, reg_addr, integ_res_sel, comp_cap_sel, cexp;
	logic [7:0] reg_wr_data, reg_rd_data, ramp_value, v;
	logic reg_wr, reg_rd, switch_clk, current_limit_threshold_bit, fault_mon_en, serial_if_en, addr_lsb;
	amp_clock_pkg::bridge_s bridge_drive;
	logic [15:0] expq[$];
	logic [15:0] exp_n;
	integer error_cnt = 0, cmp_count = 0, seed = 52, tot, mn, mx, i, sync_half = 5;
	int dtab[10] = '{`DIV_COUNT_0, `DIV_COUNT_1, `DIV_COUNT_2, `DIV_COUNT_3, `DIV_COUNT_4,
		`DIV_COUNT_5, `DIV_COUNT_6, `DIV_COUNT_7, `DIV_COUNT_8, `DIV_COUNT_9};
	int ptot[10];

	amp_clock_ctrl u_amp_clock_ctrl (.core_clk, .arst_n, .enable_pin, .mute_or_clip_pin, .sync_pin,
		.mod_comparator, .power_stage_supply_code, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
		.reg_rd_data, .switch_clk, .ramp_value, .bridge_drive, .integ_res_sel, .comp_cap_sel,
		.current_limit_threshold_bit, .fault_mon_en, .serial_if_en, .addr_lsb);
	host_model u_host_model (.core_clk, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd);

	// 50 ns core clock
	always #25 core_clk = ~core_clk;

	// external sync source, toggling every sync_half core cycles
	always begin
		repeat (sync_half) @(posedge core_clk);
		sync_pin <= ~sync_pin;
	end

	task automatic ok(input logic c, input string what);
		cmp_count++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		u_host_model.cyc(1'b1, a, d);
	endtask

	// note the masked expectation, then issue the read
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		expq.push_back({m, e & m});
		u_host_model.cyc(1'b0, a, 8'h00);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge core_clk) rd_d <= reg_rd;
	always @(negedge core_clk) begin
		if (rd_d === 1'b1) begin
			exp_n = expq.pop_front();
			ok((reg_rd_data & exp_n[15:8]) === exp_n[7:0], "read data mismatch");
		end
	end

	// every writable register at its reset value, unmapped slot 3 reading zero
	task automatic chk_regs;
		rd(`OFF_CONTROL_REG_ZERO, 8'h0F, 8'h00);
		rd(`OFF_CONTROL_REG_ONE, 8'h07, 8'h00);
		rd(`OFF_CONTROL_REG_TWO, 8'h01, 8'h00);
		rd(`OFF_CONTROL_REG_FIVE, 8'h1F, 8'h00);
		rd(`OFF_COMP_CAP_REG, 8'h07, 8'h04);
		rd(3'h3, 8'hFF, 8'h00);
	endtask

	// n switching periods rising edge to rising edge, two settling periods skipped
	task automatic meas(input int n);
		int c, k;
		logic last;
		tot = 0;
		mn = 99999;
		mx = 0;
		for (k = -2; k < n; k++) begin
			c = 0;
			do begin
				last = switch_clk;
				@(negedge core_clk);
				c++;
			end while (!(last === 1'b0 && switch_clk === 1'b1) && c < 2000);
			if (k >= 0) begin
				tot += c;
				mn = (c < mn) ? c : mn;
				mx = (c > mx) ? c : mx;
			end
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard well past the expected run length
	initial begin
		#(50 * 30000);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		tick(3);
		@(posedge core_clk);
		mute_or_clip_pin <= 1'b1;
		enable_pin <= 1'b1;
		tick(6);
		ok(addr_lsb === 1'b1 && fault_mon_en === 1'b1 && serial_if_en === 1'b1, "enable rise");
		chk_regs();
		rd(`OFF_STATUS_REG, 8'h87, 8'h84);
		$display("test reset values done");
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(`OFF_CONTROL_REG_ZERO, v);
			u_host_model.set_comp(v[6:4]);
			cexp = (v[6:4] < u_host_model.comp_min) ? u_host_model.comp_min : v[6:4];
			tick(2);
			ok(comp_cap_sel === cexp, "compensation not applied");
			rd(`OFF_CONTROL_REG_ZERO, 8'h0F, v);
			rd(`OFF_COMP_CAP_REG, 8'h07, {5'h00, cexp});
		end
		power_stage_supply_code <= 3'($random(seed));
		tick(5);
		ok(integ_res_sel === power_stage_supply_code, "supply code");
		wr(`OFF_CONTROL_REG_ONE, 8'h05);
		tick(2);
		ok(current_limit_threshold_bit === 1'b1, "threshold copy");
		wr(`OFF_CONTROL_REG_FIVE, 8'h1F);
		tick(3);
		ok(comp_cap_sel === 3'h4 && current_limit_threshold_bit === 1'b0, "soft reset outputs");
		chk_regs();
		$display("test writes and soft reset done");
		wr(`OFF_CONTROL_REG_ZERO, 8'h03);
		wr(`OFF_CONTROL_REG_TWO, 8'h01);
		mod_comparator <= 1'b1;
		tick(8);
		ok(bridge_drive === 2'b00 && fault_mon_en === 1'b1 && serial_if_en === 1'b1, "standby");
		rd(`OFF_STATUS_REG, 8'h07, 8'h02);
		rd(`OFF_CONTROL_REG_ZERO, 8'h0F, 8'h03);
		wr(`OFF_CONTROL_REG_ZERO, 8'h09);
		rd(`OFF_CONTROL_REG_ZERO, 8'h0F, 8'h09);
		u_host_model.leave_standby(8'h00);
		tick(8);
		ok(bridge_drive === 2'b10, "pair a not driven");
		rd(`OFF_STATUS_REG, 8'h07, 8'h04);
		mod_comparator <= 1'b0;
		tick(8);
		ok(bridge_drive === 2'b01, "pair b not driven");
		$display("test standby done");
		for (i = 0; i < 10; i++) begin
			wr(`OFF_CONTROL_REG_ZERO, 8'(i));
			meas(9);
			ptot[i] = tot;
			ok(tot >= 10 * dtab[i] - 1 && tot <= 10 * dtab[i] + 1, "master period");
		end
		ok(ptot[0] >= 239 && ptot[0] <= 241 && ptot[9] >= 599 && ptot[9] <= 601, "span");
		wr(`OFF_CONTROL_REG_FIVE, 8'h1E);
		meas(24);
		ok(mx - mn >= 3 && mx * 900 <= dtab[9] * 1070 + 900 && mn * 9 >= dtab[9] * 10 - 9, "spread");
		$display("test master clock done");
		sync_half = 7;
		wr(`OFF_CONTROL_REG_ONE, 8'h01);
		wr(`OFF_CONTROL_REG_ZERO, 8'h00);
		meas(4);
		ok(tot >= 110 && tot <= 114 && mx - mn <= 2, "slave period");
		$display("test slave clock done");
		@(posedge core_clk);
		enable_pin <= 1'b0;
		mute_or_clip_pin <= 1'b0;
		tick(4);
		ok(fault_mon_en === 1'b0 && serial_if_en === 1'b0 && bridge_drive === 2'b00, "shutdown");
		wr(`OFF_CONTROL_REG_ZERO, 8'h05);
		rd(`OFF_COMP_CAP_REG, 8'hFF, 8'h00);
		enable_pin <= 1'b1;
		tick(6);
		ok(addr_lsb === 1'b0, "address bit not relatched");
		chk_regs();
		tick(2);
		$display("test shutdown done");
		final_report();
	end
endmodule
`default_nettype wire
